// ===== design/psc_pkg.sv
// Constants and types for the strap loader and pin mode control.
package psc_pkg;
    localparam logic [1:0] SER_SPI_CLIENT = 2'h0;
    localparam logic [1:0] SER_I2C_HOST   = 2'h1;
    localparam logic [1:0] SER_I2C_CLIENT = 2'h2;
    localparam logic [1:0] SER_MIIM       = 2'h3;
    localparam logic       SPD_100        = 1'h1;
    localparam logic       SPD_10         = 1'h0;
    localparam logic       DPX_FULL       = 1'h1;
    localparam logic       DPX_HALF       = 1'h0;
    localparam int         STRAP_W        = 7;
    localparam int         S_P1_DPX       = 0;
    localparam int         S_P1_AN        = 1;
    localparam int         S_P2_AN        = 2;
    localparam int         S_P2_SPD       = 3;
    localparam int         S_P2_DPX       = 4;
    localparam int         S_P2_FFC       = 5;
    localparam int         S_P1_FFC       = 6;
    localparam logic [6:0] STRAP_RESET    = 7'h00;
    typedef enum logic [2:0] {
        PSC_RESET   = 3'h1,
        PSC_CAPTURE = 3'h2,
        PSC_RUN     = 3'h4
    } psc_state_e;
endpackage

// ===== design/psc_port_resolve.sv
// Resolves one port's speed, duplex and flow control from its straps and negotiation results.
`timescale 1ns/1ps
module psc_port_resolve
(
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic srst,
    // Latched straps.
    input  wire logic an_strap,
    input  wire logic spd_strap,
    input  wire logic dpx_strap,
    input  wire logic ffc_strap,
    // Negotiation results.
    input  wire logic an_done,
    input  wire logic an_ok,
    input  wire logic an_spd,
    input  wire logic an_dpx,
    input  wire logic an_fc,
    // Resolved mode.
    output logic      an_en,
    output logic      speed,
    output logic      duplex,
    output logic      flowctl
);
    import psc_pkg::*;

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            an_en   <= 1'b0;
            speed   <= SPD_10;
            duplex  <= DPX_HALF;
            flowctl <= 1'b0;
        end
        else
        begin
            an_en <= an_strap;
            if (!an_strap)
            begin
                speed  <= spd_strap;
                duplex <= dpx_strap;
            end
            else if (an_done)
            begin
                speed  <= an_ok ? an_spd : spd_strap;
                duplex <= an_ok ? an_dpx : dpx_strap;
            end
            flowctl <= ffc_strap | (an_strap & an_done & an_ok & an_fc);
        end
    end
endmodule

// ===== design/psc_strap_config.sv
// Strap capture, port mode resolution and pin role control.
//
// Contract
// R1: Port 1 duplex strap picks fallback or forced duplex, high means full.
// R2: Port 2 autonegotiation strap high enables, low disables it.
// R3: Port 2 speed strap forces 100 or 10 with autonegotiation off.
// R4: Port 2 duplex strap picks fallback or forced duplex, high means full.
// R5: Port 2 flow strap high forces flow control, else negotiation decides.
// R6: Port 1 flow strap high forces flow control, else negotiation decides.
// R7: Interrupt output is low while a link-lost status bit is set; the code drives it low only while link_lost_enable is also high.
// R8: Port 3 receive clock drives in PHY mode, input in MAC mode; the code drives it in PHY mode only while rmii_variant is low.
// R9: RMII variant outputs reference clock on receive data bit 3 pin.
// R10: Serial clock pin is output only in I2C host mode.
// R11: Serial data pin input in SPI, bidirectional otherwise; needs pull-up.
// R12: SPI read data leaves on its own output pin.
// R13: Port 1 autonegotiation strap high enables, low disables it.
// R14: Select high deselects and floats SPI output; falling edge starts transfer.
// R15: Straps sampled once at reset release, held until next reset.
`timescale 1ns/1ps
module psc_strap_config
(
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       srst,
    // Strap pin levels.
    input  wire logic       port1_duplex_strap,
    input  wire logic       port1_autoneg_strap,
    input  wire logic       port2_autoneg_strap,
    input  wire logic       port2_speed_strap,
    input  wire logic       port2_duplex_strap,
    input  wire logic       port2_force_flowctl_strap,
    input  wire logic       port1_force_flowctl_strap,
    input  wire logic       port1_speed_strap,
    // Port 1 negotiation results.
    input  wire logic       p1_an_done,
    input  wire logic       p1_an_ok,
    input  wire logic       p1_an_speed,
    input  wire logic       p1_an_duplex,
    input  wire logic       p1_an_flowctl,
    // Port 2 negotiation results.
    input  wire logic       p2_an_done,
    input  wire logic       p2_an_ok,
    input  wire logic       p2_an_speed,
    input  wire logic       p2_an_duplex,
    input  wire logic       p2_an_flowctl,
    // Resolved port modes.
    output logic            p1_an_en,
    output logic            p1_speed,
    output logic            p1_duplex,
    output logic            p1_flowctl,
    output logic            p2_an_en,
    output logic            p2_speed,
    output logic            p2_duplex,
    output logic            p2_flowctl,
    output logic            straps_valid,
    // Interface mode selection.
    input  wire logic       mii_phy_mode,
    input  wire logic       rmii_variant,
    input  wire logic [1:0] serial_mode,
    // Link-lost interrupt.
    input  wire logic       link_lost_status,
    input  wire logic       link_lost_enable,
    output logic            irq_out_low,
    // Port 3 receive pins.
    input  wire logic       rx_clk_core,
    input  wire logic       rxd3_core,
    input  wire logic       refclk_core,
    output logic            port3_rx_clock_pin_o,
    output logic            port3_rx_clock_pin_oe,
    output logic            port3_rxd3_or_refclk_out,
    // Serial management pins.
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic       scl_core_o,
    input  wire logic       sda_core_o,
    input  wire logic       sda_core_oe,
    output logic            ser_clk,
    output logic            ser_data_in,
    // SPI client pins.
    input  wire logic       spi_select_low,
    input  wire logic       spi_read_core,
    output logic            spi_read_out_pin_o,
    output logic            spi_read_out_pin_oe,
    output logic            spi_start
);
    import psc_pkg::*;

    psc_state_e               state_ff;
    psc_state_e               nxt_state;
    logic [STRAP_W-1:0]       strap_ff;
    logic                     sel_ff;
    logic                     p1_spd_ff;

    always_comb
    begin
        case (state_ff)
            PSC_RESET:   nxt_state = PSC_CAPTURE;
            PSC_CAPTURE: nxt_state = PSC_RUN;
            PSC_RUN:     nxt_state = PSC_RUN;
            default:     nxt_state = PSC_RESET;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            state_ff <= PSC_RESET;
        else
            state_ff <= nxt_state;
    end

    // R15: capture once at release.
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            strap_ff  <= STRAP_RESET;
            p1_spd_ff <= SPD_10;
        end
        else if (state_ff == PSC_RESET)
        begin
            strap_ff[S_P1_DPX] <= port1_duplex_strap;
            strap_ff[S_P1_AN]  <= port1_autoneg_strap;
            strap_ff[S_P2_AN]  <= port2_autoneg_strap;
            strap_ff[S_P2_SPD] <= port2_speed_strap;
            strap_ff[S_P2_DPX] <= port2_duplex_strap;
            strap_ff[S_P2_FFC] <= port2_force_flowctl_strap;
            strap_ff[S_P1_FFC] <= port1_force_flowctl_strap;
            p1_spd_ff          <= port1_speed_strap;
        end
    end

    assign straps_valid = (state_ff == PSC_RUN);

    // Every strap field must sit inside the capture register.
    if (S_P1_FFC >= STRAP_W || $bits(STRAP_RESET) != STRAP_W)
    begin : g_strap_fit
        $error("Strap field outside the capture register.");
    end

    // R1 R6 R13: port 1 resolution.
    psc_port_resolve u_p1
    (
        .mclk      (mclk),
        .srst      (srst | ~straps_valid),
        .an_strap  (strap_ff[S_P1_AN]),
        .spd_strap (p1_spd_ff),
        .dpx_strap (strap_ff[S_P1_DPX]),
        .ffc_strap (strap_ff[S_P1_FFC]),
        .an_done   (p1_an_done),
        .an_ok     (p1_an_ok),
        .an_spd    (p1_an_speed),
        .an_dpx    (p1_an_duplex),
        .an_fc     (p1_an_flowctl),
        .an_en     (p1_an_en),
        .speed     (p1_speed),
        .duplex    (p1_duplex),
        .flowctl   (p1_flowctl)
    );

    // R2 R3 R4 R5: port 2 resolution.
    psc_port_resolve u_p2
    (
        .mclk      (mclk),
        .srst      (srst | ~straps_valid),
        .an_strap  (strap_ff[S_P2_AN]),
        .spd_strap (strap_ff[S_P2_SPD]),
        .dpx_strap (strap_ff[S_P2_DPX]),
        .ffc_strap (strap_ff[S_P2_FFC]),
        .an_done   (p2_an_done),
        .an_ok     (p2_an_ok),
        .an_spd    (p2_an_speed),
        .an_dpx    (p2_an_duplex),
        .an_fc     (p2_an_flowctl),
        .an_en     (p2_an_en),
        .speed     (p2_speed),
        .duplex    (p2_duplex),
        .flowctl   (p2_flowctl)
    );

    // R7: active-low link-lost interrupt.
    always_ff @(posedge mclk)
    begin
        if (srst)
            irq_out_low <= 1'b1;
        else
            irq_out_low <= ~(link_lost_status & link_lost_enable);
    end

    // R8: receive clock direction.
    assign port3_rx_clock_pin_o  = rx_clk_core;
    assign port3_rx_clock_pin_oe = straps_valid & mii_phy_mode & ~rmii_variant;

    // R9: data bit 3 or reference clock.
    assign port3_rxd3_or_refclk_out = rmii_variant ? refclk_core : rxd3_core;

    // R10: serial clock direction.
    assign scl_o   = scl_core_o;
    assign scl_oe  = straps_valid & (serial_mode == SER_I2C_HOST);
    assign ser_clk = scl_i;

    // R11: serial data direction.
    assign sda_o       = sda_core_o;
    assign sda_oe      = straps_valid & (serial_mode != SER_SPI_CLIENT) & sda_core_oe;
    assign ser_data_in = sda_i;

    // R12 R14: SPI read output and select.
    assign spi_read_out_pin_o  = spi_read_core;
    assign spi_read_out_pin_oe = straps_valid & (serial_mode == SER_SPI_CLIENT)
                               & ~spi_select_low;

    always_ff @(posedge mclk)
    begin
        if (srst)
            sel_ff <= 1'b1;
        else
            sel_ff <= spi_select_low;
    end

    // R14: falling select starts transfer.
    assign spi_start = straps_valid & (serial_mode == SER_SPI_CLIENT) & sel_ff & ~spi_select_low;
endmodule

// ===== testbench/psc_host_model.sv
// Host side of a shared open-drain management pin.
`timescale 1ns/1ps
module psc_host_model
(
    input  wire logic dev_o,
    input  wire logic dev_oe,
    input  wire logic host_oe,
    output logic      pin_i
);
    assign pin_i = !((dev_oe && !dev_o) || host_oe);
endmodule

// ===== testbench/psc_strap_config_sva.sv
// Port assertions for the strap loader and pin mode control.
`timescale 1ns/1ps
module psc_strap_config_sva
import psc_pkg::*;
(
    input wire logic       mclk,
    input wire logic       srst,
    input wire logic       link_lost_status,
    input wire logic       link_lost_enable,
    input wire logic       irq_out_low,
    input wire logic [1:0] serial_mode,
    input wire logic       scl_oe,
    input wire logic       sda_oe,
    input wire logic       mii_phy_mode,
    input wire logic       rmii_variant,
    input wire logic       port3_rx_clock_pin_oe,
    input wire logic       refclk_core,
    input wire logic       port3_rxd3_or_refclk_out,
    input wire logic       spi_select_low,
    input wire logic       spi_read_out_pin_oe,
    input wire logic       spi_start,
    input wire logic       straps_valid,
    input wire logic       p1_an_en,
    input wire logic       p2_an_en
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    property p_irq;
        !$past(srst) |-> irq_out_low == !$past(link_lost_status && link_lost_enable);
    endproperty
    a_irq: assert property (p_irq) else $error("irq level wrong");
    property p_scl;
        !$past(srst) && $stable(serial_mode) |-> scl_oe == (straps_valid && serial_mode == SER_I2C_HOST);
    endproperty
    a_scl: assert property (p_scl) else $error("scl drive wrong");
    property p_sda;
        !$past(srst) && $stable(serial_mode) && serial_mode == SER_SPI_CLIENT |-> !sda_oe;
    endproperty
    a_sda: assert property (p_sda) else $error("sda driven in spi");
    property p_rxc;
        port3_rx_clock_pin_oe == (straps_valid && mii_phy_mode && !rmii_variant);
    endproperty
    a_rxc: assert property (p_rxc) else $error("rx clock drive wrong");
    property p_ref;
        rmii_variant |-> port3_rxd3_or_refclk_out == refclk_core;
    endproperty
    a_ref: assert property (p_ref) else $error("refclk out wrong");
    property p_desel;
        spi_select_low |-> !spi_read_out_pin_oe;
    endproperty
    a_desel: assert property (p_desel) else $error("spi out not floated");
    property p_start;
        $fell(spi_select_low) && serial_mode == SER_SPI_CLIENT && straps_valid && !$past(srst)
            |-> spi_start ##1 !spi_start;
    endproperty
    a_start: assert property (p_start) else $error("spi start missing");
    property p_hold;
        straps_valid && $past(straps_valid, 2) |-> $stable(p1_an_en) && $stable(p2_an_en);
    endproperty
    a_hold: assert property (p_hold) else $error("strap mode changed");
    c_irq: cover property (!irq_out_low);
    c_start: cover property (spi_start);
    c_hold: cover property (straps_valid && p2_an_en);
endmodule

// ===== testbench/psc_strap_config_test.sv
// Self-checking bench for the strap loader and pin mode control.
`timescale 1ns/1ps
module psc_strap_config_test;
    import psc_pkg::*;
    logic mclk, srst, mii_phy_mode, rmii_variant, link_lost_status, link_lost_enable, rx_clk_core, rxd3_core;
    logic refclk_core, scl_i, sda_i, scl_core_o, sda_core_o, sda_core_oe, spi_select_low, spi_read_core, host_oe;
    logic p1_an_en, p1_speed, p1_duplex, p1_flowctl, p2_an_en, p2_speed, p2_duplex, p2_flowctl, straps_valid;
    logic irq_out_low, port3_rx_clock_pin_o, port3_rx_clock_pin_oe, port3_rxd3_or_refclk_out, scl_o, scl_oe;
    logic sda_o, sda_oe, ser_clk, ser_data_in, spi_read_out_pin_o, spi_read_out_pin_oe, spi_start;
    logic port1_duplex_strap, port1_autoneg_strap, port2_autoneg_strap, port2_speed_strap, port2_duplex_strap;
    logic port2_force_flowctl_strap, port1_force_flowctl_strap, port1_speed_strap;
    logic p1_an_done, p1_an_ok, p1_an_speed, p1_an_duplex, p1_an_flowctl;
    logic p2_an_done, p2_an_ok, p2_an_speed, p2_an_duplex, p2_an_flowctl;
    logic [7:0] st;
    logic [7:0] p;
    logic [4:0] n1;
    logic [4:0] n2;
    logic [1:0] serial_mode;
    logic [7:0] pats [4] = '{8'h00, 8'hff, 8'h5a, 8'ha5};
    int fail_count = 0;
    int cmp_count = 0;
    assign {port1_speed_strap, port1_force_flowctl_strap, port2_force_flowctl_strap, port2_duplex_strap,
            port2_speed_strap, port2_autoneg_strap, port1_autoneg_strap, port1_duplex_strap} = st;
    assign {p1_an_flowctl, p1_an_duplex, p1_an_speed, p1_an_ok, p1_an_done} = n1;
    assign {p2_an_flowctl, p2_an_duplex, p2_an_speed, p2_an_ok, p2_an_done} = n2;
    psc_strap_config dut (.*);
    psc_host_model u_sda (.dev_o(sda_o), .dev_oe(sda_oe), .host_oe(host_oe), .pin_i(sda_i));
    psc_host_model u_scl (.dev_o(scl_o), .dev_oe(scl_oe), .host_oe(1'h0), .pin_i(scl_i));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end
    initial
    begin
        #100000;
        fail_count++;
        print_verdict;
    end
    initial
    begin
        {srst, spi_select_low, spi_read_core, rx_clk_core, refclk_core} = 5'h1f;
        {st, n1, n2, serial_mode, mii_phy_mode, rmii_variant, link_lost_status, link_lost_enable} = '0;
        {rxd3_core, scl_core_o, sda_core_o, sda_core_oe, host_oe} = '0;
        foreach (pats[i])
        begin
            p = pats[i];
            @(negedge mclk);
            srst = 1'h1;
            st = p;
            n1 = 5'h00;
            n2 = 5'h00;
            repeat (10) @(negedge mclk);
            srst = 1'h0;
            repeat (4) @(negedge mclk);
            st = ~p;
            repeat (2) @(negedge mclk);
            check(p1_an_en, p[1]);
            check(p1_speed, p[1] ? SPD_10 : p[7]);
            check(p2_an_en, p[2]);
            check(p2_speed, p[2] ? SPD_10 : p[3]);
            check(p1_duplex, p[1] ? DPX_HALF : p[0]);
            check(p2_duplex, p[2] ? DPX_HALF : p[4]);
            check(p2_flowctl, p[5]);
            check(p1_flowctl, p[6]);
            check(straps_valid, 1'h1);
            n1 = 5'h01;
            n2 = 5'h01;
            repeat (2) @(negedge mclk);
            check(p1_duplex, p[0]);
            check(p2_duplex, p[4]);
            n1 = 5'h1f;
            n2 = 5'h1f;
            repeat (2) @(negedge mclk);
            check(p2_speed, p[2] ? SPD_100 : p[3]);
            check(p2_flowctl, p[2] | p[5]);
            check(p1_flowctl, p[1] | p[6]);
            check(p1_speed, p[1] ? SPD_100 : p[7]);
        end
        link_lost_status = 1'h1;
        link_lost_enable = 1'h1;
        repeat (2) @(negedge mclk);
        check(irq_out_low, 1'h0);
        link_lost_enable = 1'h0;
        repeat (2) @(negedge mclk);
        check(irq_out_low, 1'h1);
        for (int k = 0; k < 4; k++)
        begin
            {mii_phy_mode, rmii_variant} = 2'(k);
            serial_mode = 2'(k);
            sda_core_oe = 1'h1;
            repeat (2) @(negedge mclk);
            check(port3_rx_clock_pin_oe, k == 2);
            check(port3_rx_clock_pin_o, rx_clk_core);
            check(ser_clk, k != 1);
            check(port3_rxd3_or_refclk_out, rmii_variant);
            check(scl_oe, k == 1);
            check(ser_data_in, k == 0);
            sda_core_oe = 1'h0;
            host_oe = 1'h1;
            repeat (2) @(negedge mclk);
            check(ser_data_in, 1'h0);
            host_oe = 1'h0;
        end
        serial_mode = SER_SPI_CLIENT;
        @(negedge mclk);
        check(spi_read_out_pin_oe, 1'h0);
        spi_select_low = 1'h0;
        #1;
        check(spi_start, 1'h1);
        @(negedge mclk);
        check(spi_start, 1'h0);
        check(spi_read_out_pin_o, spi_read_core);
        check(spi_read_out_pin_oe, 1'h1);
        print_verdict;
    end
endmodule
bind psc_strap_config psc_strap_config_sva u_sva (.*);
